/* common/mrf_pkg.sv */
package mrf_pkg;

	// Stream word and buffer geometry
	localparam int unsigned WORD_W   = 16;
	localparam int unsigned MEM_AW   = 6;
	localparam int unsigned MEM_D    = 64;
	localparam int unsigned CNT_W    = 7;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_LEN    = 8'h04;
	localparam logic [7:0] OFS_TXDATA = 8'h08;
	localparam logic [7:0] OFS_RXDATA = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_CFG    = 8'h14;
	localparam logic [7:0] OFS_HOLD   = 8'h18;
	localparam logic [7:0] OFS_DROP   = 8'h1c;

	// Control bit positions (write one to act)
	localparam int unsigned CTRL_START   = 0;
	localparam int unsigned CTRL_FLUSH   = 1;
	localparam int unsigned CTRL_FRST    = 2;
	localparam int unsigned CTRL_RXCLR   = 3;

	// Configuration field positions
	localparam int unsigned CFG_MODE_LSB  = 0;
	localparam int unsigned CFG_FACT_LSB  = 4;
	localparam int unsigned CFG_CYC_LSB   = 8;
	localparam int unsigned CFG_TAPS_LSB  = 16;
	localparam int unsigned CFG_CHAN_LSB  = 24;

	// Status field positions
	localparam int unsigned ST_SRC_BUSY   = 0;
	localparam int unsigned ST_FLUSHING   = 1;
	localparam int unsigned ST_RX_NE      = 2;
	localparam int unsigned ST_FRST       = 3;
	localparam int unsigned ST_RXCNT_LSB  = 8;
	localparam int unsigned ST_TXCNT_LSB  = 16;

	// Reset values
	localparam logic [31:0] CFG_RESET = 32'h0101_0110;
	localparam logic [6:0]  LEN_RESET = 7'h01;

	// Rate modes
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_INTERP = 2'h1;
	localparam logic [1:0] MODE_DECIM  = 2'h2;

	// Timing counts
	localparam logic [1:0] FRST_CYCLES = 2'h2;
	localparam logic [6:0] SINK_MARGIN = 7'h08;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Words driven toward the filter input
	typedef struct packed {
		logic              valid;
		logic              first;
		logic              last;
		logic [WORD_W-1:0] word;
	} mrf_src_t;

	// Words arriving from the filter output
	typedef struct packed {
		logic              req;
		logic              first;
		logic              last;
		logic [WORD_W-1:0] word;
	} mrf_snk_t;

endpackage

/* hw/mrf_stream_host.sv */
`timescale 1ns/1ps

module mrf_stream_host
	import mrf_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              rstn_in,
	// AXI4-Lite write address and data
	input  wire logic [7:0]        s_axi_awaddr_in,
	input  wire logic              s_axi_awvalid_in,
	output logic                   s_axi_awready_out,
	input  wire logic [31:0]       s_axi_wdata_in,
	input  wire logic [3:0]        s_axi_wstrb_in,
	input  wire logic              s_axi_wvalid_in,
	output logic                   s_axi_wready_out,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp_out,
	output logic                   s_axi_bvalid_out,
	input  wire logic              s_axi_bready_in,
	// AXI4-Lite read
	input  wire logic [7:0]        s_axi_araddr_in,
	input  wire logic              s_axi_arvalid_in,
	output logic                   s_axi_arready_out,
	output logic [31:0]            s_axi_rdata_out,
	output logic [1:0]             s_axi_rresp_out,
	output logic                   s_axi_rvalid_out,
	input  wire logic              s_axi_rready_in,
	// Source side, feeding the filter input
	input  wire logic              fin_req_in,
	output logic                   fin_avail_out,
	output mrf_src_t               fin_src_out,
	// Sink side, taking the filter output
	input  wire mrf_snk_t          fout_snk_in,
	output logic                   fout_avail_out,
	// Synchronous reset toward the filter
	output logic                   filt_rst_out
);

	typedef struct packed {
		logic              aw_have;
		logic [7:0]        aw_addr;
		logic              w_have;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rd_pend;
		logic [7:0]        ar_addr;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [31:0]       cfg;
		logic [6:0]        src_len;
		logic [MEM_AW-1:0] tx_wr;
		logic [CNT_W-1:0]  tx_cnt;
		logic              src_active;
		logic [CNT_W-1:0]  src_idx;
		mrf_src_t          src;
		logic              flushing;
		logic [19:0]       flush_left;
		logic [1:0]        rst_left;
		logic [MEM_AW-1:0] rx_wr;
		logic [MEM_AW-1:0] rx_rd;
		logic [CNT_W-1:0]  rx_cnt;
		logic [15:0]       drop_cnt;
	} mrf_state_t;

	mrf_state_t        st_reg;
	mrf_state_t        st_next;
	logic [1:0]        rst_sync_reg;
	logic              rst_n;
	logic              tx_we;
	logic [WORD_W-1:0] tx_q;
	logic              rx_we;
	logic [WORD_W-1:0] rx_q;
	logic              ctrl_wr;
	logic              rx_pop;

	// Input hold per sample the filter needs, in clocks
	function automatic logic [11:0] hold_cycles(input logic [31:0] cfg);
		logic [7:0] cyc;
		logic [3:0] fac;
		cyc = cfg[CFG_CYC_LSB +: 8];
		fac = cfg[CFG_FACT_LSB +: 4];
		if (cfg[CFG_MODE_LSB +: 2] == MODE_INTERP)
			hold_cycles = 12'(cyc) * 12'(fac);
		else
			hold_cycles = {4'h0, cyc};
	endfunction

	// Output spacing in decimation, in clocks
	function automatic logic [11:0] out_period(input logic [31:0] cfg);
		// Operands widened first, or the product loses its upper bits
		out_period = 12'(cfg[CFG_CYC_LSB +: 8]) * 12'(cfg[CFG_FACT_LSB +: 4]);
	endfunction

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++)
			merge[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
	endfunction

	// Reset release through two flops
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// Samples queued by software for the filter input
	mrf_word_mem u_tx_mem (
		.clk_in    (clk_in),
		.we_in     (tx_we),
		.waddr_in  (st_reg.tx_wr),
		.wdata_in  (st_reg.w_data[WORD_W-1:0]),
		.raddr_in  (st_next.src_idx[MEM_AW-1:0]),
		.rdata_out (tx_q)
	);

	// Results collected from the filter output
	mrf_word_mem u_rx_mem (
		.clk_in    (clk_in),
		.we_in     (rx_we),
		.waddr_in  (st_reg.rx_wr),
		.wdata_in  (fout_snk_in.word),
		.raddr_in  (st_reg.rx_rd),
		.rdata_out (rx_q)
	);

	// Write happens once both address and data are held
	assign ctrl_wr = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
	assign tx_we   = ctrl_wr && st_reg.aw_addr == OFS_TXDATA && st_reg.w_strb[1:0] != 2'h0
		&& st_reg.tx_cnt < CNT_W'(MEM_D) && !st_reg.src_active;
	// Only keep words flagged first while a request is up
	assign rx_we   = fout_snk_in.req && fout_snk_in.first && st_reg.rx_cnt < CNT_W'(MEM_D);
	assign rx_pop  = st_reg.rd_pend && st_reg.ar_addr == OFS_RXDATA && st_reg.rx_cnt != '0;

	// Next-state logic for bus, source and sink
	always_comb
	begin
		st_next = st_reg;

		// Address and data taken in either order
		if (s_axi_awvalid_in && s_axi_awready_out)
		begin
			st_next.aw_have = 1'b1;
			st_next.aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out)
		begin
			st_next.w_have = 1'b1;
			st_next.w_data = s_axi_wdata_in;
			st_next.w_strb = s_axi_wstrb_in;
		end
		if (st_reg.bvalid && s_axi_bready_in)
			st_next.bvalid = 1'b0;

		// Sink capture; drops counted once the buffer is full
		if (rx_we)
		begin
			st_next.rx_wr = st_reg.rx_wr + 1'b1;
		end
		else if (fout_snk_in.req && fout_snk_in.first)
		begin
			st_next.drop_cnt = st_reg.drop_cnt + 1'b1;
		end
		st_next.rx_cnt = st_reg.rx_cnt + CNT_W'(rx_we) - CNT_W'(rx_pop);

		// Source side: a request sampled while a packet is active or flushing gets a word next edge
		st_next.src.valid = 1'b0;
		st_next.src.first = 1'b0;
		st_next.src.last  = 1'b0;
		if (st_reg.flushing)
		begin
			// Zeros for taps*channels*cycles clocks clear the past samples
			st_next.flush_left = st_reg.flush_left - 1'b1;
			if (st_reg.flush_left == 20'h1)
				st_next.flushing = 1'b0;
			if (fin_req_in)
			begin
				st_next.src.valid = 1'b1;
				st_next.src.word  = '0;
			end
		end
		else if (st_reg.src_active && fin_req_in)
		begin
			// Packet framed by first and last flags
			st_next.src.valid = 1'b1;
			st_next.src.word  = tx_q;
			st_next.src.first = st_reg.src_idx == '0;
			st_next.src.last  = st_reg.src_idx == st_reg.src_len - 1'b1;
			st_next.src_idx   = st_reg.src_idx + 1'b1;
			if (st_next.src.last)
			begin
				st_next.src_active = 1'b0;
				st_next.tx_cnt     = '0;
				st_next.tx_wr      = '0;
			end
		end

		// Filter reset pulse countdown
		if (st_reg.rst_left != 2'h0)
			st_next.rst_left = st_reg.rst_left - 1'b1;

		// Register writes
		if (ctrl_wr)
		begin
			st_next.aw_have = 1'b0;
			st_next.w_have  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = RESP_OKAY;
			case (st_reg.aw_addr)
				OFS_CTRL:
				begin
					if (st_reg.w_strb[0] && st_reg.w_data[CTRL_START] && st_reg.src_len != '0
						&& !st_reg.flushing)
					begin
						st_next.src_active = 1'b1;
						st_next.src_idx    = '0;
					end
					if (st_reg.w_strb[0] && st_reg.w_data[CTRL_FLUSH] && !st_reg.src_active)
					begin
						st_next.flush_left = 20'(st_reg.cfg[CFG_TAPS_LSB +: 8])
							* 20'(st_reg.cfg[CFG_CHAN_LSB +: 4]) * 20'(st_reg.cfg[CFG_CYC_LSB +: 8]);
						st_next.flushing   = st_next.flush_left != 20'h0;
					end
					if (st_reg.w_strb[0] && st_reg.w_data[CTRL_FRST])
					begin
						// Held more than one clock for the filter's synchronous reset
						st_next.rst_left   = FRST_CYCLES;
						st_next.src_active = 1'b0;
						st_next.flushing   = 1'b0;
					end
					if (st_reg.w_strb[0] && st_reg.w_data[CTRL_RXCLR])
					begin
						st_next.rx_wr    = '0;
						st_next.rx_rd    = '0;
						st_next.rx_cnt   = '0;
						st_next.drop_cnt = '0;
					end
				end
				OFS_LEN:
				begin
					if (st_reg.w_strb[0] && !st_reg.src_active)
						st_next.src_len = st_reg.w_data[6:0] > 7'(MEM_D) ? 7'(MEM_D) : st_reg.w_data[6:0];
				end
				OFS_TXDATA:
				begin
					if (tx_we)
					begin
						st_next.tx_wr  = st_reg.tx_wr + 1'b1;
						st_next.tx_cnt = st_reg.tx_cnt + 1'b1;
					end
				end
				OFS_CFG:
				begin
					st_next.cfg = merge(st_reg.cfg, st_reg.w_data, st_reg.w_strb);
				end
				OFS_RXDATA, OFS_STATUS, OFS_HOLD, OFS_DROP:
				begin
					st_next.bresp = RESP_OKAY; // Read-only, write ignored
				end
				default:
				begin
					st_next.bresp = RESP_SLVERR;
				end
			endcase
		end

		// Read: address taken, answered on the following edge
		if (s_axi_arvalid_in && s_axi_arready_out)
		begin
			st_next.rd_pend = 1'b1;
			st_next.ar_addr = s_axi_araddr_in;
		end
		if (st_reg.rd_pend)
		begin
			st_next.rd_pend = 1'b0;
			st_next.rvalid  = 1'b1;
			st_next.rresp   = RESP_OKAY;
			st_next.rdata   = '0;
			case (st_reg.ar_addr)
				OFS_CTRL:   st_next.rdata = '0;
				OFS_LEN:    st_next.rdata = {25'h0, st_reg.src_len};
				OFS_TXDATA: st_next.rdata = '0;
				OFS_RXDATA:
				begin
					if (rx_pop)
					begin
						st_next.rdata = {16'h0, rx_q};
						st_next.rx_rd = st_reg.rx_rd + 1'b1;
					end
				end
				OFS_STATUS:
				begin
					st_next.rdata[ST_SRC_BUSY] = st_reg.src_active;
					st_next.rdata[ST_FLUSHING] = st_reg.flushing;
					st_next.rdata[ST_RX_NE]    = st_reg.rx_cnt != '0;
					st_next.rdata[ST_FRST]     = st_reg.rst_left != 2'h0;
					st_next.rdata[ST_RXCNT_LSB +: 8] = {1'b0, st_reg.rx_cnt};
					st_next.rdata[ST_TXCNT_LSB +: 8] = {1'b0, st_reg.tx_cnt};
				end
				OFS_CFG:    st_next.rdata = st_reg.cfg;
				OFS_HOLD:   st_next.rdata = {4'h0, out_period(st_reg.cfg), 4'h0, hold_cycles(st_reg.cfg)};
				OFS_DROP:   st_next.rdata = {16'h0, st_reg.drop_cnt};
				default:    st_next.rresp = RESP_SLVERR;
			endcase
		end
		if (st_reg.rvalid && s_axi_rready_in)
			st_next.rvalid = 1'b0;
	end

	// One register for all state; sequencers idle after reset
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg         <= '0;
			st_reg.cfg     <= CFG_RESET;
			st_reg.src_len <= LEN_RESET;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// Bus handshakes; one write and one read in flight
	assign s_axi_awready_out = !st_reg.aw_have && !st_reg.bvalid;
	assign s_axi_wready_out  = !st_reg.w_have && !st_reg.bvalid;
	assign s_axi_bvalid_out  = st_reg.bvalid;
	assign s_axi_bresp_out   = st_reg.bresp;
	assign s_axi_arready_out = !st_reg.rd_pend && !st_reg.rvalid;
	assign s_axi_rvalid_out  = st_reg.rvalid;
	assign s_axi_rdata_out   = st_reg.rdata;
	assign s_axi_rresp_out   = st_reg.rresp;

	// Availability flags toward the filter
	assign fin_avail_out  = st_reg.src_active || st_reg.flushing;
	// Margin leaves room for words sent after the flag falls
	assign fout_avail_out = st_reg.rx_cnt < CNT_W'(MEM_D) - SINK_MARGIN;
	assign fin_src_out    = st_reg.src;
	assign filt_rst_out   = st_reg.rst_left != 2'h0;

endmodule

/* hw/mrf_word_mem.sv */
`timescale 1ns/1ps

module mrf_word_mem
	import mrf_pkg::*;
(
	// Clock
	input  wire logic              clk_in,
	// Write port
	input  wire logic              we_in,
	input  wire logic [MEM_AW-1:0] waddr_in,
	input  wire logic [WORD_W-1:0] wdata_in,
	// Read port, data one cycle after address
	input  wire logic [MEM_AW-1:0] raddr_in,
	output logic      [WORD_W-1:0] rdata_out
);

	logic [WORD_W-1:0] mem_reg [MEM_D];

	// No reset on contents, like any block memory
	always_ff @(posedge clk_in)
	begin
		if (we_in)
		begin
			mem_reg[waddr_in] <= wdata_in;
		end
		rdata_out <= mem_reg[raddr_in];
	end

endmodule

/* tb/mrf_filt_model.sv */
`timescale 1ns/1ps

module mrf_filt_model
	import mrf_pkg::*;
(
	// Clock, reset and stall pattern
	input  wire logic     clk_in,
	input  wire logic     rstn_in,
	input  wire logic     stall_in,
	input  wire logic     filt_rst_in,
	// Input side, master sink
	input  wire logic     fin_avail_in,
	input  wire mrf_src_t fin_src_in,
	output logic          fin_req_out,
	// Output side, master source
	input  wire logic     fout_avail_in,
	output mrf_snk_t      fout_snk_out
);
	logic              req_d;
	logic              nreq;
	logic [WORD_W-1:0] q[$];

	// Stands for a parallel filter with streaming ports, run tethered: never zeroed by time-out
	// Single-phase echo filter, no pipeline; stored samples survive filter reset
	always @(posedge clk_in or negedge rstn_in)
		if (!rstn_in)
		begin
			fin_req_out <= 1'b0;
			req_d <= 1'b0;
			fout_snk_out <= '0;
		end
		else
		begin
			nreq = fout_avail_in && !stall_in && !filt_rst_in && q.size() > 0;
			fout_snk_out.req <= nreq;
			fout_snk_out.last <= 1'b0;
			// Word follows request by a cycle; junk when idle
			if (fout_snk_out.req && nreq)
			begin
				fout_snk_out.first <= 1'b1;
				fout_snk_out.word <= q.pop_front();
			end
			else
			begin
				fout_snk_out.first <= 1'b0;
				fout_snk_out.word <= ~fout_snk_out.word;
			end
			if (req_d && fin_src_in.valid)
				q.push_back(fin_src_in.word);
			fin_req_out <= fin_avail_in && !stall_in && !filt_rst_in;
			req_d <= fin_req_out;
		end
endmodule

/* tb/mrf_stream_host_chk.sv */
`timescale 1ns/1ps

module mrf_host_chk
	import mrf_pkg::*;
(
	// Clock, reset and bus
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic        s_axi_arvalid_in,
	input  wire logic        s_axi_arready_out,
	input  wire logic        s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	input  wire logic [31:0] s_axi_rdata_out,
	input  wire logic        s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [1:0]  s_axi_bresp_out,
	// Stream links
	input  wire logic        fin_req_in,
	input  wire logic        fin_avail_out,
	input  wire mrf_src_t    fin_src_out,
	input  wire mrf_snk_t    fout_snk_in,
	input  wire logic        fout_avail_out,
	input  wire logic        filt_rst_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	a_valid_needs_req: assert property (fin_src_out.valid |-> $past(fin_req_in))
		else $error("word sent without request");
	a_valid_needs_avail: assert property (fin_src_out.valid |-> $past(fin_avail_out))
		else $error("word sent while source empty");
	a_flags_need_valid: assert property ((fin_src_out.first || fin_src_out.last) |-> fin_src_out.valid)
		else $error("packet flag without valid");
	a_last_ends_packet: assert property (fin_src_out.last |-> ##[0:1] !fin_avail_out)
		else $error("source still available after last word");
	a_rst_two_cycles: assert property ($rose(filt_rst_out) |=> filt_rst_out ##1 !filt_rst_out)
		else $error("filter reset not two cycles");
	a_read_latency: assert property (s_axi_arvalid_in && s_axi_arready_out |-> ##2 s_axi_rvalid_out)
		else $error("read answer late");
	a_rdata_stands: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
		s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data dropped early");
	a_bresp_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
		s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write answer dropped early");
	a_sink_stop_cause: assert property ($fell(fout_avail_out) |-> $past(fout_snk_in.req && fout_snk_in.first))
		else $error("sink stopped without capture");
endmodule

bind mrf_stream_host mrf_host_chk mrf_host_chk_inst (.*);

/* tb/mrf_stream_host_tb_top.sv */
`timescale 1ns/1ps

module mrf_stream_host_tb_top
	import mrf_pkg::*;
;
	logic clk_in, rstn_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
	logic s_axi_rready_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out, fin_req_in, fin_avail_out, fout_avail_out, filt_rst_out, stall, flsh;
	logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd, v;
	logic [31:0] seed = 32'h6bb8;
	logic [3:0]  s_axi_wstrb_in, f;
	logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, m;
	logic [7:0]  c;
	logic [15:0] txw[64];
	mrf_src_t    fin_src_out;
	mrf_snk_t    fout_snk_in;
	int          mismatches, tests_run, pidx, plen, seen, i, k;

	mrf_stream_host mrf_stream_host_inst (.*);
	mrf_filt_model mrf_filt_model_inst (.clk_in(clk_in), .rstn_in(rstn_in), .stall_in(stall),
		.filt_rst_in(filt_rst_out), .fin_avail_in(fin_avail_out), .fin_src_in(fin_src_out),
		.fin_req_out(fin_req_in), .fout_avail_in(fout_avail_out), .fout_snk_out(fout_snk_in));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Interp holds for every phase, others for one result
	function automatic logic [31:0] hold_exp(logic [1:0] md, logic [7:0] cy, logic [3:0] fa);
		logic [11:0] p;
		p = 12'(cy) * 12'(fa);
		return {4'h0, p, 4'h0, (md == MODE_INTERP) ? p : 12'(cy)};
	endfunction

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			mismatches++;
			$display("MISMATCH %0t: saw %h expected %h", $time, s, e);
		end
	endtask

	task automatic give_verdict(input bit to);
		mismatches += to;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n, dl;
		dl = int'(rnd() % 32'd4);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		for (n = 0; n < 200; n++)
		begin
			@(posedge clk_in);
			if (s_axi_awready_out)
				s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out)
				s_axi_wvalid_in <= 1'b0;
			if (s_axi_bvalid_out && s_axi_bready_in)
				break;
			s_axi_bready_in <= (n >= dl);
		end
		s_axi_bready_in <= 1'b0;
		chk(32'(s_axi_bresp_out), 32'(er));
		if (n == 200)
			give_verdict(1);
	endtask

	task automatic axr(input logic [7:0] a, input logic [1:0] er);
		int n, dl;
		dl = int'(rnd() % 32'd4);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		for (n = 0; n < 200; n++)
		begin
			@(posedge clk_in);
			if (s_axi_arready_out)
				s_axi_arvalid_in <= 1'b0;
			if (s_axi_rvalid_out && s_axi_rready_in)
				break;
			s_axi_rready_in <= (n >= dl);
		end
		s_axi_rready_in <= 1'b0;
		rd = s_axi_rdata_out;
		chk(32'(s_axi_rresp_out), 32'(er));
		if (n == 200)
			give_verdict(1);
	endtask

	// Bounded status poll; the host has no completion pin
	task automatic poll(input logic [31:0] mk, input logic [31:0] want);
		int n;
		for (n = 0; n < 400; n++)
		begin
			axr(OFS_STATUS, RESP_OKAY);
			if ((rd & mk) == want)
				break;
		end
		if (n == 400)
			give_verdict(1);
	endtask

	initial
	begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	// Random stall of the filter model on both links
	always @(posedge clk_in)
		stall <= rnd() > 32'h9000_0000;

	// Every word toward the filter against the packet or flush
	always @(posedge clk_in)
		if (rstn_in && fin_src_out.valid)
		begin
			seen++;
			if (flsh)
				chk(32'({fin_src_out.first, fin_src_out.word}), 32'h0);
			else
			begin
				chk(32'({fin_src_out.first, fin_src_out.last, fin_src_out.word}),
					32'({pidx == 0, pidx == plen - 1, txw[pidx % 64]}));
				pidx++;
			end
		end

	initial
	begin
		{rstn_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, flsh} = '0;
		{s_axi_arvalid_in, s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
		s_axi_wstrb_in = 4'hf;
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		axr(OFS_CFG, RESP_OKAY);
		chk(rd, CFG_RESET);
		axr(OFS_LEN, RESP_OKAY);
		chk(rd, 32'(LEN_RESET));
		axr(8'h20, RESP_SLVERR);
		chk(rd, 32'h0);
		axw(8'h24, 32'h1, RESP_SLVERR);
		// Each rate mode twice with random factor and cycle count
		for (i = 0; i < 6; i++)
		begin
			m = 2'(i % 3);
			f = 4'(rnd() % 32'd15 + 32'd1);
			c = 8'(rnd() % 32'd255 + 32'd1);
			v = 32'({4'h1, 8'h02, c, f, 2'h0, m});
			axw(OFS_CFG, v, RESP_OKAY);
			axr(OFS_CFG, RESP_OKAY);
			chk(rd, v);
			axr(OFS_HOLD, RESP_OKAY);
			chk(rd, hold_exp(m, c, f));
		end
		// Packets: past the sink margin, single word, full memory
		for (k = 0; k < 3; k++)
		begin
			plen = (k == 0) ? 60 : (k == 1) ? 1 : 64;
			axw(OFS_LEN, 32'(plen), RESP_OKAY);
			for (i = 0; i < plen; i++)
			begin
				txw[i] = 16'(rnd());
				axw(OFS_TXDATA, {16'h0, txw[i]}, RESP_OKAY);
			end
			axr(OFS_STATUS, RESP_OKAY);
			chk(rd & 32'hff0000, 32'(plen) << 16);
			pidx = 0;
			axw(OFS_CTRL, 32'h1, RESP_OKAY);
			poll(32'h1, 32'h0);
			chk(32'(pidx), 32'(plen));
			for (i = 0; i < plen; i++)
			begin
				poll(32'h4, 32'h4);
				axr(OFS_RXDATA, RESP_OKAY);
				chk(rd, {16'h0, txw[i]});
			end
			axr(OFS_STATUS, RESP_OKAY);
			chk(rd & 32'hff04, 32'h0);
		end
		// Short flush, then a packet cut by filter reset
		seen = 0;
		flsh = 1'b1;
		axw(OFS_CFG, 32'h0102_0300, RESP_OKAY);
		axw(OFS_CTRL, 32'h2, RESP_OKAY);
		poll(32'h2, 32'h0);
		chk(32'(seen <= 6), 32'h1);
		flsh = 1'b0;
		plen = 40;
		axw(OFS_LEN, 32'(plen), RESP_OKAY);
		for (i = 0; i < plen; i++)
		begin
			txw[i] = 16'(rnd());
			axw(OFS_TXDATA, {16'h0, txw[i]}, RESP_OKAY);
		end
		pidx = 0;
		axw(OFS_CTRL, 32'h1, RESP_OKAY);
		axw(OFS_CTRL, 32'h4, RESP_OKAY);
		poll(32'h9, 32'h0);
		chk(32'(pidx < plen), 32'h1);
		poll(32'hff00, 32'(seen) << 8);
		axr(OFS_DROP, RESP_OKAY);
		chk(rd, 32'h0);
		axw(OFS_CTRL, 32'h8, RESP_OKAY);
		axr(OFS_STATUS, RESP_OKAY);
		chk(rd & 32'hff04, 32'h0);
		axr(OFS_RXDATA, RESP_OKAY);
		chk(rd, 32'h0);
		give_verdict(0);
	end
endmodule
